// ### hdl/eeprom_defines.svh
// Constants for the two-wire serial memory target
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH
`define MEM_ADDR_W    13
`define MEM_DEPTH     8192
`define PAGE_OFS_W    5
`define PAGE_BYTES    32
`define TARGET_CODE   4'ha
`define ERASED_BYTE   8'hff
`define BYTE_BITS     4'h8
`define MACK_SEEN     4'h9
`define IDX_TARGET    2'h0
`define IDX_ADDR_HI   2'h1
`define IDX_ADDR_LO   2'h2
`define IDX_DATA      2'h3
`define CLK_MHZ       20
`define PROG_TIME_US  5000
`define PROG_CYCLES   (`PROG_TIME_US * `CLK_MHZ)
`define PROG_CNT_W    17
`define COMMIT_DONE   6'h20
`endif

// ### hdl/eeprom_pkg.sv
// Types for the two-wire serial memory target
`include "eeprom_defines.svh"
package eeprom_pkg;
   typedef enum logic [4:0] {
      st_idle = 5'b00001,
      st_rx   = 5'b00010,
      st_ack  = 5'b00100,
      st_tx   = 5'b01000,
      st_mack = 5'b10000
   } state_t;

   typedef struct packed {
      state_t                  state;
      logic [3:0]              bit_cnt;
      logic [1:0]              byte_idx;
      logic [7:0]              shreg;
      logic                    rw;
      logic [`MEM_ADDR_W-1:0]  addr;
      logic [7:0]              addr_hi;
      logic                    wp_lat;
      logic                    pending;
      logic [`PAGE_BYTES-1:0]  valid;
      logic                    sda_oe_n;
   } ctl_t;

   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } bus_ev_t;
endpackage

// ### hdl/serial_eeprom_i2c_target.sv
// Two-wire serial memory target with page write and sequential read
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_defines.svh"
module serial_eeprom_i2c_target
   import eeprom_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
   input  wire logic       clk,       // System clock, 20 MHz
   input  wire logic       nrst,      // Asynchronous reset, active low
   input  wire logic       scl_i,     // Bus clock from controller
   input  wire logic       sda_i,     // Bus data level
   output var  logic       sda_o,     // Data drive level, always low
   output var  logic       sda_oe_n,  // Data pull-down enable, low drives
   input  wire logic [2:0] strap_i,   // Select straps, bit0 to bit2
   input  wire logic       wp_i,      // Write protect input
   output var  logic       busy       // Program cycle in progress
);
   logic [2:0] scl_s, sda_s, wp_s;
   logic [2:0] strap_s0, strap_s1, strap_s2;
   logic       scl_f, sda_f, scl_p, sda_p, wp_f;
   logic [2:0] strap_f;
   logic       next_scl_f, next_sda_f, next_wp_f;
   logic [2:0] next_strap_f;
   bus_ev_t    ev;

   // Pins pass three stages; a level counts once the last two agree
   always_comb begin
      next_scl_f   = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
      next_sda_f   = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
      next_wp_f    = (wp_s[1] == wp_s[2]) ? wp_s[2] : wp_f;
      next_strap_f = strap_f;
      for (int i = 0; i < 3; i++) begin
         if (strap_s1[i] == strap_s2[i]) begin
            next_strap_f[i] = strap_s2[i];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_s    <= 3'h7;
         sda_s    <= 3'h7;
         wp_s     <= 3'h0;
         strap_s0 <= 3'h0;
         strap_s1 <= 3'h0;
         strap_s2 <= 3'h0;
         scl_f    <= 1'b1;
         sda_f    <= 1'b1;
         scl_p    <= 1'b1;
         sda_p    <= 1'b1;
         wp_f     <= 1'b0;
         strap_f  <= 3'h0;
      end else begin
         scl_s    <= {scl_s[1:0], scl_i};
         sda_s    <= {sda_s[1:0], sda_i};
         wp_s     <= {wp_s[1:0], wp_i};
         strap_s0 <= strap_i;
         strap_s1 <= strap_s0;
         strap_s2 <= strap_s1;
         scl_f    <= next_scl_f;
         sda_f    <= next_sda_f;
         scl_p    <= scl_f;
         sda_p    <= sda_f;
         wp_f     <= next_wp_f;
         strap_f  <= next_strap_f;
      end
   end

   always_comb begin
      ev.start = scl_f & scl_p & sda_p & ~sda_f;
      ev.stop  = scl_f & scl_p & ~sda_p & sda_f;
      ev.rise  = scl_f & ~scl_p;
      ev.fall  = ~scl_f & scl_p;
   end

   logic [7:0]             mem [`MEM_DEPTH]
                           = '{default: `ERASED_BYTE};
   logic [7:0]             pbuf [`PAGE_BYTES];
   ctl_t                   ctl, next_ctl;
   logic [`PROG_CNT_W-1:0] prog_cnt, next_prog_cnt;
   logic [5:0]             commit_idx, next_commit_idx;
   logic [`MEM_ADDR_W-`PAGE_OFS_W-1:0] page, next_page;
   logic                   buf_we, launch, tx_load, match;
   logic [`PAGE_OFS_W-1:0] ofs;

   assign ofs = ctl.addr[`PAGE_OFS_W-1:0];

   function automatic logic [`MEM_ADDR_W-1:0] inc_in_page(
      input logic [`MEM_ADDR_W-1:0] a);
      inc_in_page = {a[`MEM_ADDR_W-1:`PAGE_OFS_W],
                     a[`PAGE_OFS_W-1:0] + `PAGE_OFS_W'(1)};
   endfunction

   always_comb begin
      next_ctl = ctl;
      buf_we   = 1'b0;
      launch   = 1'b0;
      tx_load  = 1'b0;
      match    = (ctl.shreg[7:4] == `TARGET_CODE)
               && (ctl.shreg[3:1] == strap_f) && (prog_cnt == '0);
      if (ev.stop) begin
         next_ctl.state    = st_idle;
         next_ctl.sda_oe_n = 1'b1;
         if (ctl.pending) begin
            launch           = 1'b1;
            next_ctl.pending = 1'b0;
         end
      end else if (ev.start) begin
         next_ctl.state    = st_rx;
         next_ctl.bit_cnt  = 4'h0;
         next_ctl.byte_idx = `IDX_TARGET;
         next_ctl.sda_oe_n = 1'b1;
      end else begin
         unique case (ctl.state)
            st_idle: begin
            end
            st_rx: begin
               if (ev.rise && ctl.bit_cnt != `BYTE_BITS) begin
                  next_ctl.shreg   = {ctl.shreg[6:0], sda_f};
                  next_ctl.bit_cnt = ctl.bit_cnt + 4'h1;
               end else if (ev.fall && ctl.bit_cnt == `BYTE_BITS) begin
                  next_ctl.state    = st_ack;
                  next_ctl.sda_oe_n = 1'b0;
                  unique case (ctl.byte_idx)
                     `IDX_TARGET: begin
                        next_ctl.rw = ctl.shreg[0];
                        if (!match) begin
                           next_ctl.state    = st_idle;
                           next_ctl.sda_oe_n = 1'b1;
                        end
                     end
                     `IDX_ADDR_HI: next_ctl.addr_hi = ctl.shreg;
                     `IDX_ADDR_LO: next_ctl.addr =
                        {ctl.addr_hi[`MEM_ADDR_W-9:0], ctl.shreg};
                     `IDX_DATA: begin
                        if (ctl.wp_lat) begin
                           next_ctl.state    = st_idle;
                           next_ctl.sda_oe_n = 1'b1;
                           next_ctl.pending  = 1'b0;
                           next_ctl.valid    = '0;
                        end else begin
                           buf_we              = 1'b1;
                           next_ctl.valid[ofs] = 1'b1;
                           next_ctl.pending    = 1'b1;
                           next_ctl.addr       = inc_in_page(ctl.addr);
                        end
                     end
                  endcase
               end
            end
            st_ack: begin
               if (ev.fall) begin
                  next_ctl.sda_oe_n = 1'b1;
                  next_ctl.bit_cnt  = 4'h0;
                  if (ctl.byte_idx == `IDX_TARGET && ctl.rw) begin
                     tx_load = 1'b1;
                  end else begin
                     next_ctl.state = st_rx;
                     if (ctl.byte_idx == `IDX_ADDR_LO) begin
                        next_ctl.wp_lat = wp_f;
                     end
                     if (ctl.byte_idx != `IDX_DATA) begin
                        next_ctl.byte_idx = ctl.byte_idx + 2'h1;
                     end
                  end
               end
            end
            st_tx: begin
               if (ev.rise) begin
                  next_ctl.bit_cnt = ctl.bit_cnt + 4'h1;
               end else if (ev.fall) begin
                  if (ctl.bit_cnt == `BYTE_BITS) begin
                     next_ctl.state    = st_mack;
                     next_ctl.sda_oe_n = 1'b1;
                  end else begin
                     next_ctl.sda_oe_n = ctl.shreg[7];
                     next_ctl.shreg    = {ctl.shreg[6:0], 1'b0};
                  end
               end
            end
            st_mack: begin
               if (ev.rise) begin
                  if (sda_f) begin
                     next_ctl.state = st_idle;
                  end else begin
                     next_ctl.bit_cnt = `MACK_SEEN;
                  end
               end else if (ev.fall && ctl.bit_cnt == `MACK_SEEN) begin
                  tx_load = 1'b1;
               end
            end
         endcase
      end
      if (tx_load) begin
         next_ctl.state    = st_tx;
         next_ctl.bit_cnt  = 4'h0;
         next_ctl.sda_oe_n = mem[ctl.addr][7];
         next_ctl.shreg    = {mem[ctl.addr][6:0], 1'b0};
         next_ctl.addr     = ctl.addr + `MEM_ADDR_W'(1);
      end
      if (launch) begin
         next_ctl.valid = '0;
      end
   end

   // Program cycle: commits the page buffer while busy is held
   always_comb begin
      next_prog_cnt   = prog_cnt;
      next_commit_idx = commit_idx;
      next_page       = page;
      if (launch) begin
         next_prog_cnt   = `PROG_CNT_W'(PROG_CYCLES);
         next_commit_idx = 6'h0;
         next_page       = ctl.addr[`MEM_ADDR_W-1:`PAGE_OFS_W];
      end else begin
         if (prog_cnt != '0) begin
            next_prog_cnt = prog_cnt - `PROG_CNT_W'(1);
         end
         if (commit_idx != `COMMIT_DONE) begin
            next_commit_idx = commit_idx + 6'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctl        <= '{state: st_idle, sda_oe_n: 1'b1, default: '0};
         prog_cnt   <= '0;
         commit_idx <= `COMMIT_DONE;
         page       <= '0;
         sda_o      <= 1'b0;
         sda_oe_n   <= 1'b1;
         busy       <= 1'b0;
      end else begin
         ctl        <= next_ctl;
         prog_cnt   <= next_prog_cnt;
         commit_idx <= next_commit_idx;
         page       <= next_page;
         sda_o      <= 1'b0;
         sda_oe_n   <= next_ctl.sda_oe_n;
         busy       <= next_prog_cnt != '0;
      end
   end

   logic [`PAGE_BYTES-1:0] commit_mask;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         commit_mask <= '0;
      end else if (launch) begin
         commit_mask <= ctl.valid;
      end
   end

   always_ff @(posedge clk) begin
      if (buf_we) begin
         pbuf[ofs] <= ctl.shreg;
      end
      if (commit_idx != `COMMIT_DONE && commit_mask[commit_idx[4:0]]) begin
         mem[{page, commit_idx[4:0]}] <= pbuf[commit_idx[4:0]];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence target_end_s;
      ev.fall && ctl.state == st_rx && ctl.bit_cnt == `BYTE_BITS
      && ctl.byte_idx == `IDX_TARGET;
   endsequence

   sequence data_end_s;
      ev.fall && ctl.state == st_rx && ctl.bit_cnt == `BYTE_BITS
      && ctl.byte_idx == `IDX_DATA && !ev.stop && !ev.start;
   endsequence

   start_to_rx_a: assert property (ev.start && !ev.stop |=>
      ctl.state == st_rx && ctl.bit_cnt == 4'h0)
      else $error("start did not open target byte");
   stop_idle_a: assert property (ev.stop |=> ctl.state == st_idle
      ##1 sda_oe_n)
      else $error("stop did not return to idle");
   target_miss_a: assert property (target_end_s ##0 !match |=>
      ctl.state == st_idle ##1 sda_oe_n)
      else $error("mismatched target was acknowledged");
   busy_nack_a: assert property (target_end_s ##0 busy |=>
      ##1 sda_oe_n)
      else $error("target acknowledged during program cycle");
   wp_refuse_a: assert property (data_end_s ##0 ctl.wp_lat |=>
      !ctl.pending && ctl.state == st_idle ##1 sda_oe_n)
      else $error("protected data byte accepted");
   low_only_a: assert property (sda_o == 1'b0
      && (sda_oe_n || ctl.state inside {st_ack, st_tx}))
      else $error("data line driven high or out of turn");
   prog_launch_a: assert property (ev.stop && ctl.pending |=>
      busy [*8])
      else $error("program cycle not launched by stop");
   page_wrap_a: assert property (data_end_s ##0 !ctl.wp_lat
      ##0 (ofs == 5'h1f) |=> ofs == 5'h0
      && ctl.addr[12:5] == $past(ctl.addr[12:5]))
      else $error("page offset did not wrap inside page");
   read_wrap_a: assert property (tx_load && ctl.addr == 13'h1fff
      |=> ctl.addr == 13'h0)
      else $error("read address did not wrap to zero");
   ack_drive_a: assert property (target_end_s ##0 match |=>
      ctl.state == st_ack ##1 !sda_oe_n)
      else $error("matched target not acknowledged");
endmodule
`default_nettype wire

// ### verif/bus_ctrl_model.sv
// Bus controller model that drives the clock and data of the two-wire link
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
   input  wire logic clk,   // Bench clock, aligns each frame
   input  wire logic sda,   // Resolved data line level
   output var  logic scl,   // Bus clock, high while idle
   output var  logic pull   // High pulls the data line low
);
   initial begin
      scl  = 1'b1;
      pull = 1'b0;
   end

   // One clock period: 250 ns low, 150 ns high, sampled late in high
   task automatic bit_slot(input logic val, output logic seen);
      #50 pull = ~val;
      #200 scl = 1'b1;
      #100 seen = sda;
      #50 scl = 1'b0;
   endtask

   task automatic start_cond();
      @(posedge clk);
      #3 pull = 1'b0;
      #300 scl = 1'b1;
      #100 pull = 1'b1;
      #100 scl = 1'b0;
   endtask

   task automatic stop_cond();
      #50 pull = 1'b1;
      #200 scl = 1'b1;
      #100 pull = 1'b0;
      #300;
   endtask

   // Eight bits out or in, then the ninth clock
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack_out);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(tx[i], b);
         rx[i] = b;
      end
      bit_slot(ack_in, ack_out);
   endtask
endmodule
`default_nettype wire

// ### verif/serial_eeprom_i2c_target_bench.sv
// Self-checking bench for the two-wire serial memory target
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_target_bench
   import eeprom_pkg::*;
;
   localparam int unsigned PROG  = 200;
   localparam int unsigned LIMIT = 20000;
   localparam logic [2:0]  STRAP = 3'h5;
   localparam logic [7:0]  WR_T  = {4'ha, STRAP, 1'b0};
   localparam logic [7:0]  RD_T  = {4'ha, STRAP, 1'b1};

   logic       clk;
   logic       nrst;
   logic       scl;
   logic       pull;
   wire  logic sda;
   logic       sda_o;
   logic       sda_oe_n;
   logic [2:0] strap;
   logic       wp;
   logic       busy;
   int         fail_count;
   int         comparisons;
   int         cycles;

   // Pull-up: low only when someone pulls
   assign sda = (pull || (!sda_oe_n && !sda_o)) ? 1'b0 : 1'b1;

   serial_eeprom_i2c_target #(.PROG_CYCLES(PROG)) dut_u (
      .clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .strap_i(strap), .wp_i(wp), .busy(busy));

   bus_ctrl_model ctrl_u (.clk(clk), .sda(sda), .scl(scl), .pull(pull));

   always #25 clk = ~clk;

   task automatic final_report();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fail_count++;
         final_report();
      end
   end

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check1(input logic got, input logic exp);
      check8({7'h0, got}, {7'h0, exp});
   endtask

   // Send a byte and judge the ninth-clock answer (low means acknowledge)
   task automatic send(input logic [7:0] b, input logic ack_exp);
      logic [7:0] rx;
      logic       a;
      ctrl_u.xfer(b, 1'b1, rx, a);
      check1(a, !ack_exp);
   endtask

   task automatic get(input logic [7:0] exp, input logic last);
      logic [7:0] rx;
      logic       a;
      ctrl_u.xfer(8'hff, last, rx, a);
      check8(rx, exp);
   endtask

   task automatic set_addr(input logic [15:0] a);
      ctrl_u.start_cond();
      send(WR_T, 1'b1);
      send(a[15:8], 1'b1);
      send(a[7:0], 1'b1);
   endtask

   task automatic read_at(input logic [15:0] a, input logic [7:0] exp);
      set_addr(a);
      ctrl_u.start_cond();
      send(RD_T, 1'b1);
      get(exp, 1'b1);
      ctrl_u.stop_cond();
   endtask

   task automatic wait_idle();
      for (int n = 0; n < PROG + 100 && busy !== 1'b0; n++) begin
         @(posedge clk);
      end
      check1(busy, 1'b0);
   endtask

   task automatic erased_read();
      set_addr(16'h0040);
      ctrl_u.start_cond();
      send(RD_T, 1'b1);
      get(8'hff, 1'b0);
      get(8'hff, 1'b1);
      ctrl_u.stop_cond();
   endtask

   task automatic page_write_wrap();
      set_addr(16'hfffe);
      send(8'ha1, 1'b1);
      send(8'ha2, 1'b1);
      send(8'ha3, 1'b1);
      ctrl_u.stop_cond();
      repeat (4) @(posedge clk);
      check1(busy, 1'b1);
      ctrl_u.start_cond();
      send(WR_T, 1'b0);
      ctrl_u.stop_cond();
      wait_idle();
      set_addr(16'h1fff);
      ctrl_u.start_cond();
      send(RD_T, 1'b1);
      get(8'ha2, 1'b0);
      get(8'hff, 1'b0);
      get(8'hff, 1'b1);
      ctrl_u.stop_cond();
      read_at(16'h1fe0, 8'ha3);
      read_at(16'h1ffe, 8'ha1);
      ctrl_u.start_cond();
      send(RD_T, 1'b1);
      get(8'ha2, 1'b1);
      ctrl_u.stop_cond();
   endtask

   task automatic protected_write();
      @(posedge clk);
      #3 wp = 1'b1;
      set_addr(16'h0005);
      send(8'h55, 1'b0);
      ctrl_u.stop_cond();
      @(posedge clk);
      #3 wp = 1'b0;
      repeat (4) @(posedge clk);
      check1(busy, 1'b0);
      read_at(16'h0005, 8'hff);
   endtask

   task automatic mismatch_ignored();
      ctrl_u.start_cond();
      send({4'ha, 3'h2, 1'b0}, 1'b0);
      send(WR_T, 1'b0);
      ctrl_u.stop_cond();
      ctrl_u.start_cond();
      send({4'hb, STRAP, 1'b0}, 1'b0);
      ctrl_u.stop_cond();
   endtask

   initial begin
      clk         = 1'b0;
      nrst        = 1'b0;
      strap       = STRAP;
      wp          = 1'b0;
      fail_count  = 0;
      comparisons = 0;
      cycles      = 0;
      repeat (6) @(posedge clk);
      #3 nrst = 1'b1;
      repeat (6) @(posedge clk);
      erased_read();
      page_write_wrap();
      protected_write();
      mismatch_ignored();
      final_report();
   end
endmodule
`default_nettype wire
